// *** rtl/prr_pkg.sv ***
// Purpose: Constants and types for the peripheral register read-back block
// Assumes: Byte-wide register port, 16-bit byte addresses
// Notes: Overview of operation
package prr_pkg;
  localparam int PRR_PORTS = 8;
  localparam logic [15:0] PRR_CMP_HIGH = 16'hF774;
  localparam logic [15:0] PRR_CMP_LOW = 16'hF775;
  localparam logic [15:0] PRR_TIMER = 16'hFFB3;
  localparam logic [15:0] PRR_PW_CTRL = 16'hFFD0;
  localparam logic [15:0] PRR_PW_UPPER = 16'hFFD1;
  localparam logic [15:0] PRR_PW_LOWER = 16'hFFD2;
  localparam logic [15:0] PRR_CMP_SEL = 16'hF776;
  localparam logic [7:0] PRR_ALL_ONES = 8'hFF;
  localparam logic [7:0] PRR_ZERO = 8'h00;
  localparam logic [7:0] PRR_ONE = 8'h01;
  localparam logic [7:0] PRR_CMP_SEL_MASK = 8'h01;
  localparam logic [15:0] PRR_LATCH_ADDR [PRR_PORTS] = '{16'hFFD4, 16'hFFD5, 16'hFFD6,
    16'hFFD8, 16'hFFD9, 16'hFFDA, 16'hFFDB, 16'hFFDC};
  localparam logic [15:0] PRR_DIR_ADDR [PRR_PORTS] = '{16'hFFE4, 16'hFFE5, 16'hFFE6,
    16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFEB, 16'hFFEC};

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prr_bus_s;

  typedef struct packed {
    logic [PRR_PORTS-1:0][7:0] latch;
    logic [PRR_PORTS-1:0][7:0] dir;
    logic [PRR_PORTS-1:0][7:0] pin_meta;
    logic [PRR_PORTS-1:0][7:0] pin_sync;
    logic [7:0] pw_ctrl;
    logic [7:0] pw_upper;
    logic [7:0] pw_lower;
    logic [7:0] cmp_a_high;
    logic [7:0] cmp_a_low;
    logic [7:0] cmp_b_high;
    logic [7:0] cmp_b_low;
    logic cmp_sel;
    logic [7:0] reload_value;
    logic [7:0] counter;
    logic [7:0] rdata;
  } prr_state_s;
endpackage : prr_pkg

// *** rtl/prr_regs.sv ***
// Purpose: Peripheral register bank with shared and write-only addresses
// Assumes: One clock, synchronous active-low reset, pins synchronised here
// Notes: The timer counts down and reloads; compare select picks A or B
`timescale 1ns/1ps
`default_nettype none
module prr_regs
  import prr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire prr_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [PRR_PORTS-1:0][7:0] pin_in,
  output logic [PRR_PORTS-1:0][7:0] pin_out,
  output logic [PRR_PORTS-1:0][7:0] pin_oe,
  output logic [7:0] pulse_width_control,
  output logic [15:0] pulse_width_value,
  output logic [15:0] compare_a,
  output logic [15:0] compare_b,
  output logic [7:0] reload_timer_counter
);
  prr_state_s s;
  prr_state_s next_s;
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = PRR_ZERO;
    for (int i = 0; i < PRR_PORTS; i++)
    begin
      if (bus.addr == PRR_LATCH_ADDR[i])
      begin
        rd_mux = (s.latch[i] & s.dir[i]) | (s.pin_sync[i] & ~s.dir[i]);
      end
      if (bus.addr == PRR_DIR_ADDR[i])
      begin
        rd_mux = PRR_ALL_ONES;
      end
    end
    unique case (bus.addr)
      PRR_PW_CTRL, PRR_PW_UPPER, PRR_PW_LOWER: rd_mux = PRR_ALL_ONES;
      PRR_TIMER: rd_mux = s.counter;
      PRR_CMP_HIGH: rd_mux = s.cmp_sel ? s.cmp_b_high : s.cmp_a_high;
      PRR_CMP_LOW: rd_mux = s.cmp_sel ? s.cmp_b_low : s.cmp_a_low;
      PRR_CMP_SEL: rd_mux = s.cmp_sel ? PRR_CMP_SEL_MASK : PRR_ZERO;
      default: ;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.pin_meta = pin_in;
    next_s.pin_sync = s.pin_meta;
    next_s.rdata = bus.rd ? rd_mux : PRR_ZERO;
    if (s.counter == PRR_ZERO)
    begin
      next_s.counter = s.reload_value;
    end
    else
    begin
      next_s.counter = s.counter - PRR_ONE;
    end
    if (bus.wr)
    begin
      // Read-modify-write by the core lands here as a full byte write
      for (int i = 0; i < PRR_PORTS; i++)
      begin
        if (bus.addr == PRR_LATCH_ADDR[i])
        begin
          next_s.latch[i] = bus.wdata;
        end
        if (bus.addr == PRR_DIR_ADDR[i])
        begin
          next_s.dir[i] = bus.wdata;
        end
      end
      unique case (bus.addr)
        PRR_PW_CTRL: next_s.pw_ctrl = bus.wdata;
        PRR_PW_UPPER: next_s.pw_upper = bus.wdata;
        PRR_PW_LOWER: next_s.pw_lower = bus.wdata;
        PRR_TIMER: next_s.reload_value = bus.wdata;
        PRR_CMP_HIGH:
        begin
          if (s.cmp_sel)
          begin
            next_s.cmp_b_high = bus.wdata;
          end
          else
          begin
            next_s.cmp_a_high = bus.wdata;
          end
        end
        PRR_CMP_LOW:
        begin
          if (s.cmp_sel)
          begin
            next_s.cmp_b_low = bus.wdata;
          end
          else
          begin
            next_s.cmp_a_low = bus.wdata;
          end
        end
        PRR_CMP_SEL: next_s.cmp_sel = |(bus.wdata & PRR_CMP_SEL_MASK);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  generate
    for (genvar g = 0; g < PRR_PORTS; g++)
    begin : g_port
      assign pin_out[g] = s.latch[g];
      assign pin_oe[g] = s.dir[g];
    end
  endgenerate

  assign rdata = s.rdata;
  assign pulse_width_control = s.pw_ctrl;
  assign pulse_width_value = {s.pw_upper, s.pw_lower};
  assign compare_a = {s.cmp_a_high, s.cmp_a_low};
  assign compare_b = {s.cmp_b_high, s.cmp_b_low};
  assign reload_timer_counter = s.counter;

  // Assertions
  write_only_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && (bus.addr == PRR_DIR_ADDR[2] || bus.addr == PRR_PW_CTRL)
    |=> rdata == PRR_ALL_ONES)
    else $error("write-only register did not read as all ones");
  dir_to_oe_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_DIR_ADDR[2] |=> pin_oe[2] == $past(bus.wdata))
    else $error("direction write did not reach output enable");
  latch_to_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_LATCH_ADDR[0] |=> pin_out[0] == $past(bus.wdata))
    else $error("latch write did not reach pin output");
  bit_clear_rmw_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_DIR_ADDR[1] |=> s.dir[1] == $past(bus.wdata))
    else $error("full byte write-back not stored");
  port_read_mix_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_LATCH_ADDR[2]
    |=> rdata == (($past(s.latch[2]) & $past(s.dir[2])) |
      ($past(s.pin_sync[2]) & ~$past(s.dir[2]))))
    else $error("port read did not mix pins and latch");
  port_out_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_LATCH_ADDR[3] && s.dir[3] == PRR_ALL_ONES
    |=> rdata == $past(s.latch[3]))
    else $error("output port read not latch");
  timer_read_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_TIMER |=> rdata == $past(s.counter))
    else $error("timer read not live count");
  timer_write_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_TIMER |=> s.reload_value == $past(bus.wdata))
    else $error("timer write did not set reload");
  compare_shared_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_HIGH && s.cmp_sel
    |=> compare_b[15:8] == $past(bus.wdata) && $stable(compare_a))
    else $error("compare high write went to wrong register");
  pw_wo_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_PW_UPPER |=> rdata == PRR_ALL_ONES)
    else $error("pulse width byte not read as ones");
  byte_read_once_a: assert property (@(posedge clk) disable iff (!reset_n)
    !bus.rd |=> rdata == PRR_ZERO)
    else $error("read data stood outside its cycle");

  pw_ctrl_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_PW_CTRL
    |=> pulse_width_control == $past(bus.wdata))
    else $error("pulse width control write not stored");

  pw_upper_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_PW_UPPER
    |=> pulse_width_value[15:8] == $past(bus.wdata))
    else $error("pulse width upper write not stored");

  pw_lower_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_PW_LOWER
    |=> pulse_width_value[7:0] == $past(bus.wdata))
    else $error("pulse width lower write not stored");

  pw_ctrl_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_PW_CTRL
    |=> rdata == PRR_ALL_ONES)
    else $error("pulse width control not read as ones");

  pw_lower_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_PW_LOWER
    |=> rdata == PRR_ALL_ONES)
    else $error("pulse width lower not read as ones");

  pw_ctrl_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && bus.addr == PRR_PW_CTRL)
    |=> $stable(pulse_width_control))
    else $error("pulse width control changed without write");

  pw_value_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && (bus.addr == PRR_PW_UPPER || bus.addr == PRR_PW_LOWER))
    |=> $stable(pulse_width_value))
    else $error("pulse width value changed without write");

  write_only_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_PW_CTRL
    |=> $stable(pulse_width_control))
    else $error("read disturbed write-only register");

  counter_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    s.counter == PRR_ZERO
    |=> reload_timer_counter == $past(s.reload_value))
    else $error("counter did not reload at zero");

  counter_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    s.counter != PRR_ZERO
    |=> reload_timer_counter == $past(s.counter) - PRR_ONE)
    else $error("counter did not step down");

  timer_write_count_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_TIMER && s.counter != PRR_ZERO
    |=> reload_timer_counter == $past(s.counter) - PRR_ONE)
    else $error("timer write reached the counter");

  reload_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && bus.addr == PRR_TIMER)
    |=> $stable(s.reload_value))
    else $error("reload value changed without write");

  timer_read_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_TIMER
    |=> $stable(s.reload_value))
    else $error("timer read disturbed reload value");

  cmp_a_high_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_HIGH && !s.cmp_sel
    |=> compare_a[15:8] == $past(bus.wdata))
    else $error("compare A high write not stored");

  cmp_b_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_HIGH && !s.cmp_sel
    |=> $stable(compare_b))
    else $error("compare A write disturbed compare B");

  cmp_a_low_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_LOW && !s.cmp_sel
    |=> compare_a[7:0] == $past(bus.wdata))
    else $error("compare A low write not stored");

  cmp_b_low_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_LOW && s.cmp_sel
    |=> compare_b[7:0] == $past(bus.wdata))
    else $error("compare B low write not stored");

  cmp_high_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_CMP_HIGH
    |=> rdata == ($past(s.cmp_sel) ? $past(compare_b[15:8]) : $past(compare_a[15:8])))
    else $error("compare high read wrong byte");

  cmp_low_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_CMP_LOW
    |=> rdata == ($past(s.cmp_sel) ? $past(compare_b[7:0]) : $past(compare_a[7:0])))
    else $error("compare low read wrong byte");

  cmp_sel_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && bus.addr == PRR_CMP_SEL
    |=> s.cmp_sel == |($past(bus.wdata) & PRR_CMP_SEL_MASK))
    else $error("compare select write not stored");

  cmp_sel_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && bus.addr == PRR_CMP_SEL
    |=> rdata == ($past(s.cmp_sel) ? PRR_CMP_SEL_MASK : PRR_ZERO))
    else $error("compare select read wrong");

  cmp_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && (bus.addr == PRR_CMP_HIGH || bus.addr == PRR_CMP_LOW))
    |=> $stable(compare_a) && $stable(compare_b))
    else $error("compare changed without write");

  cmp_sel_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && bus.addr == PRR_CMP_SEL)
    |=> $stable(s.cmp_sel))
    else $error("compare select changed without write");

  write_no_data_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr
    |=> rdata == PRR_ZERO)
    else $error("write produced read data");

  reset_outputs_a: assert property (@(posedge clk)
    !reset_n
    |=> pin_oe == '0 && pin_out == '0 && rdata == PRR_ZERO)
    else $error("pins driven after reset");

  reset_values_a: assert property (@(posedge clk)
    !reset_n
    |=> reload_timer_counter == PRR_ZERO && pulse_width_control == PRR_ZERO && compare_a == '0)
    else $error("registers not cleared by reset");

  // Checks per port
  generate
    for (genvar g = 0; g < PRR_PORTS; g++)
    begin : g_port_chk
      latch_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr && bus.addr == PRR_LATCH_ADDR[g]
        |=> pin_out[g] == $past(bus.wdata))
        else $error("latch write not on pin output");

      dir_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr && bus.addr == PRR_DIR_ADDR[g]
        |=> pin_oe[g] == $past(bus.wdata))
        else $error("direction write not on output enable");

      dir_read_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr == PRR_DIR_ADDR[g]
        |=> rdata == PRR_ALL_ONES)
        else $error("direction read not all ones");

      input_bits_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr == PRR_LATCH_ADDR[g]
        |=> (rdata & ~$past(pin_oe[g])) == ($past(s.pin_sync[g]) & ~$past(pin_oe[g])))
        else $error("input bits not read from pins");

      output_bits_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr == PRR_LATCH_ADDR[g]
        |=> (rdata & $past(pin_oe[g])) == ($past(pin_out[g]) & $past(pin_oe[g])))
        else $error("output bits not read from latch");

      meta_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1
        |=> s.pin_meta[g] == $past(pin_in[g]))
        else $error("first pin stage missed input");

      sync_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1
        |=> s.pin_sync[g] == $past(s.pin_meta[g]))
        else $error("second pin stage missed first");

      latch_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(bus.wr && bus.addr == PRR_LATCH_ADDR[g])
        |=> $stable(pin_out[g]))
        else $error("latch changed without write");

      dir_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(bus.wr && bus.addr == PRR_DIR_ADDR[g])
        |=> $stable(pin_oe[g]))
        else $error("direction changed without write");

      latch_read_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr == PRR_LATCH_ADDR[g]
        |=> $stable(pin_out[g]))
        else $error("port read disturbed latch");

      dir_read_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr == PRR_DIR_ADDR[g]
        |=> $stable(pin_oe[g]))
        else $error("direction read disturbed register");
    end
  endgenerate

  cov_dir_write_c: cover property (@(posedge clk) bus.wr && bus.addr == PRR_DIR_ADDR[2]);
  cov_port_read_c: cover property (@(posedge clk) bus.rd && bus.addr == PRR_LATCH_ADDR[2]);
  cov_timer_reload_c: cover property (@(posedge clk) s.counter == PRR_ZERO);
  cov_cmp_b_c: cover property (@(posedge clk) bus.wr && bus.addr == PRR_CMP_LOW && s.cmp_sel);
endmodule : prr_regs
`default_nettype wire

// *** tb/peripheral_register_readback_test.sv ***
// Purpose: Self-checking bench for the register read-back block
// Assumes: Down counter reloading at zero, compare select at its own address
// Notes: Random port values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module peripheral_register_readback_test
  import prr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  prr_bus_s bus;
  logic [7:0] rdata, rv, d, l, pwc, cnt;
  logic [PRR_PORTS-1:0][7:0] pin_in = '0;
  logic [PRR_PORTS-1:0][7:0] pin_out, pin_oe;
  logic [15:0] pwv, ca, cb;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 32'h53807ea1;
  prr_regs u_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pulse_width_control(pwc),
    .pulse_width_value(pwv), .compare_a(ca), .compare_b(cb), .reload_timer_counter(cnt));
  prr_cpu_model u_cpu (.clk(clk), .bus(bus), .rdata(rdata));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] port_view(input logic [7:0] lt, dr, p);
    return (lt & dr) | (p & ~dr);
  endfunction : port_view
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    #(50 * 3000);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < PRR_PORTS; i++)
    begin
      d = $random(seed);
      l = $random(seed);
      pin_in[i] <= $random(seed);
      u_cpu.wr(PRR_DIR_ADDR[i], d);
      u_cpu.rd(PRR_DIR_ADDR[i], rv);
      chk(rv, PRR_ALL_ONES);
      chk(pin_oe[i], d);
      u_cpu.wr(PRR_LATCH_ADDR[i], l);
      u_cpu.rd(PRR_LATCH_ADDR[i], rv);
      chk(rv, port_view(l, d, pin_in[i]));
      chk(pin_out[i], l);
    end
    u_cpu.wr(PRR_DIR_ADDR[3], PRR_ALL_ONES);
    u_cpu.wr(PRR_LATCH_ADDR[3], 8'h96);
    u_cpu.rd(PRR_LATCH_ADDR[3], rv);
    chk(rv, 8'h96);
    u_cpu.wr(PRR_DIR_ADDR[4], PRR_ZERO);
    u_cpu.rd(PRR_LATCH_ADDR[4], rv);
    chk(rv, pin_in[4]);
    $display("test ports done");
    u_cpu.wr(PRR_DIR_ADDR[2], 8'h3F);
    u_cpu.bit_clear(PRR_DIR_ADDR[2], 0);
    chk(pin_oe[2], 8'hFE);
    u_cpu.wr(PRR_DIR_ADDR[2], 8'h3F & ~PRR_ONE);
    chk(pin_oe[2], 8'h3E);
    u_cpu.wr(PRR_PW_CTRL, 8'h5A);
    u_cpu.wr(PRR_PW_UPPER, 8'hC3);
    u_cpu.wr(PRR_PW_LOWER, 8'h3C);
    u_cpu.rd(PRR_PW_CTRL, rv);
    chk(rv, PRR_ALL_ONES);
    u_cpu.rd(PRR_PW_UPPER, rv);
    chk(rv, PRR_ALL_ONES);
    u_cpu.rd(PRR_PW_LOWER, rv);
    chk(rv, PRR_ALL_ONES);
    chk(pwc, 8'h5A);
    chk(pwv, 16'hC33C);
    $display("test write-only done");
    u_cpu.wr(PRR_CMP_SEL, PRR_ZERO);
    u_cpu.wr(PRR_CMP_HIGH, 8'hA1);
    u_cpu.wr(PRR_CMP_LOW, 8'hB2);
    u_cpu.wr(PRR_CMP_SEL, PRR_ONE);
    u_cpu.wr(PRR_CMP_HIGH, 8'hC3);
    u_cpu.wr(PRR_CMP_LOW, 8'hD4);
    chk(ca, 16'hA1B2);
    chk(cb, 16'hC3D4);
    u_cpu.rd(PRR_CMP_LOW, rv);
    chk(rv, 8'hD4);
    u_cpu.wr(PRR_TIMER, 8'h09);
    for (int k = 0; k < 300 && cnt !== PRR_ZERO; k++)
      @(posedge clk);
    @(posedge clk);
    chk(cnt, 8'h09);
    u_cpu.rd(PRR_TIMER, rv);
    chk(rv, 8'h08);
    u_cpu.rd(16'h1234, rv);
    chk(rv, PRR_ZERO);
    $display("test shared addresses done");
    wrap_up();
  end
endmodule : peripheral_register_readback_test
`default_nettype wire

// *** tb/prr_cpu_model.sv ***
// Purpose: CPU core model issuing byte reads and writes
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Each access ends on an edge with all strobes low
`timescale 1ns/1ps
`default_nettype none
module prr_cpu_model
  import prr_pkg::*;
(
  input wire logic clk,
  output prr_bus_s bus,
  input wire logic [7:0] rdata
);
  initial bus = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd
  // Read whole byte, clear one bit, write whole byte back
  task automatic bit_clear(input logic [15:0] a, input int b);
    logic [7:0] v;
    rd(a, v);
    wr(a, v & ~(8'h01 << b));
  endtask : bit_clear
endmodule : prr_cpu_model
`default_nettype wire
